// ==== rtl/pecs_counters.sv ====
// Contract
// - Ctr0 event 7 counts joint TLB instruction accesses like I-TLB misses.
// - Ctr1 events 7/8 count joint TLB instruction/data lookups missing.
// - Ctr0 event 9 counts every instruction cache access incl replays.
// - Ctr1 event 9 counts instruction cache misses issuing bus requests.
// - Event 10: ctr0 cached loads/stores, ctr1 dcache line writebacks.
// - Event 11: either counter counts data cache misses.
// - Ctr1 event 19 counts failed store-conditional instructions.
// - Ctr1 event 20 counts prefetches hitting in the cache.
// - Ctr0 event 23 counts every exception taken.
// - Event 49: ctr0 instruction triggers, ctr1 data triggers.
// - Ctr0 event 24 counts data cache controller fixup cycles.
// - Event 25: ctr0 fetch-no-valid cycles, ctr1 pipeline-stall cycles.
// - Ctr0 event 18 counts no-issue cycles, overlapping stalls once.
// - Ctr0 event 37 icache miss stalls, minus TLB stalls, redirect window.
// - Ctr1 event 37 dmiss load waits; ctr0 event 39 dmiss outstanding.
// - Ctr0 events 40/41/42 uncached, muldiv, cop2 stalls; ctr1 42 extension.
// - Event 43: ctr0 scratchpad bubbles minus redirect, ctr1 data spad.
// - Ctr0 events 44/45/46 cache-op, load-use, move-from stalls.
// - Ctr1 events 53/55 fill buffer full, write buffer full stalls.
// - Events 28-30 come from optional modules, active only if present.
// - Occupancy events bin by buffer size as tabulated.
// - Counters are 32-bit read/write, undefined after reset.
// - No counting in debug mode or with error level set.
// - Six-bit event field in control selects counted event.
// - Interrupt enable gates counter bit 31 onto interrupt request.
// - Mode-dependent events honour user, kernel, exception-level bits.
`timescale 1ns/1ns
module pecs_counters
(
  input wire logic mclk,
  input wire logic rst,
  input wire pecs_pkg::pecs_evt_t evt,
  input wire pecs_pkg::pecs_cfg_t cfg,
  input wire pecs_pkg::pecs_mode_t mode,
  input wire logic [3:0] fill_occ,
  input wire logic [3:0] wtb_occ,
  input wire logic sel,
  input wire logic ctl_we,
  input wire logic cnt_we,
  input wire logic [31:0] wdata,
  output logic [31:0] ctl_rdata,
  output logic [31:0] cnt_rdata,
  output logic irq
);
  // ==========================================================
  // Registers
  logic [31:0] ctl_q [2];
  logic [31:0] cnt_q [2];
  logic [2:0] redir_q;
  logic [2:0] redir_d;
  pecs_pkg::pecs_state_t st_q;
  pecs_pkg::pecs_state_t st_d;
  logic [31:0] ctl_rd_q;
  logic [31:0] cnt_rd_q;
  logic irq_q;
  logic [1:0] inc;

  // ==========================================================
  // Redirect window: four cycles after a redirect are masked
  assign redir_d = evt.redirect ? pecs_pkg::REDIR_LOAD :
                   (redir_q != 3'h0) ? redir_q - 3'h1 : 3'h0;
  assign st_d = (redir_d != 3'h0) ? pecs_pkg::PECS_REDIR : pecs_pkg::PECS_RUN;
  wire in_redir = (st_q == pecs_pkg::PECS_REDIR);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      redir_q <= 3'h0;
      st_q <= pecs_pkg::PECS_RUN;
    end
    else
    begin
      redir_q <= redir_d;
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Occupancy bins; small buffer thresholds unless big one fitted
  wire [3:0] fill_lo = cfg.fill_big ? pecs_pkg::OCC8_LO : pecs_pkg::OCC4_LO;
  wire [3:0] fill_hi = cfg.fill_big ? pecs_pkg::OCC8_HI : pecs_pkg::OCC4_HI;
  wire [3:0] wtb_lo = cfg.wtb_big ? pecs_pkg::OCC8_LO : pecs_pkg::OCC4_LO;
  wire [3:0] wtb_hi = cfg.wtb_big ? pecs_pkg::OCC8_HI : pecs_pkg::OCC4_HI;
  wire fill_b0 = fill_occ < fill_lo;
  wire fill_b1 = (fill_occ >= fill_lo) && (fill_occ < fill_hi);
  wire fill_b2 = fill_occ >= fill_hi;
  wire wtb_b0 = wtb_occ < wtb_lo;
  wire wtb_b1 = (wtb_occ >= wtb_lo) && (wtb_occ < wtb_hi);
  wire wtb_b2 = wtb_occ >= wtb_hi;

  // ==========================================================
  // Privilege qualification
  wire blocked = mode.debug_mode | mode.error_level_bit;

  // ==========================================================
  // Event selection per counter
  logic [5:0] ev [2];
  logic hit [2];
  logic mdep [2];
  assign ev[0] = ctl_q[0][pecs_pkg::CTL_EVT_HI:pecs_pkg::CTL_EVT_LO];
  assign ev[1] = ctl_q[1][pecs_pkg::CTL_EVT_HI:pecs_pkg::CTL_EVT_LO];

  always_comb
  begin
    hit[0] = 1'b0;
    mdep[0] = 1'b1;
    case (ev[0])
      pecs_pkg::EV_CYCLES: begin hit[0] = 1'b1; mdep[0] = 1'b0; end
      pecs_pkg::EV_JOINT_I: hit[0] = evt.instr_tb_miss;
      pecs_pkg::EV_JOINT_D: hit[0] = evt.joint_d_acc;
      pecs_pkg::EV_ICACHE: hit[0] = evt.icache_acc;
      pecs_pkg::EV_DCACHE: hit[0] = evt.dcache_acc;
      pecs_pkg::EV_DMISS: hit[0] = evt.dcache_miss;
      pecs_pkg::EV_STALL:
      begin
        hit[0] = evt.fetch_no_valid | evt.alu_stall;
        mdep[0] = 1'b0;
      end
      pecs_pkg::EV_EXC: hit[0] = evt.exc_taken;
      pecs_pkg::EV_FIXUP: hit[0] = evt.dc_fixup;
      pecs_pkg::EV_GSTALL:
      begin
        hit[0] = evt.fetch_no_valid;
        mdep[0] = 1'b0;
      end
      pecs_pkg::EV_MOD_B: hit[0] = cfg.ispr & evt.ispr_evt;
      pecs_pkg::EV_MOD_C: hit[0] = cfg.cext & evt.cext_evt;
      pecs_pkg::EV_MISS_ST:
        hit[0] = evt.icache_miss_stall & ~evt.instr_tb_stall & ~in_redir;
      pecs_pkg::EV_DMISS_CY:
      begin
        hit[0] = evt.dmiss_outstanding;
        mdep[0] = 1'b0;
      end
      pecs_pkg::EV_UNC_ST: hit[0] = evt.uncached_stall;
      pecs_pkg::EV_MULDIV_ST: hit[0] = evt.muldiv_stall;
      pecs_pkg::EV_COP2_ST: hit[0] = evt.cop2_stall;
      pecs_pkg::EV_SPR_ST: hit[0] = evt.ispr_multi & ~in_redir;
      pecs_pkg::EV_CACHE_ST:
      begin
        hit[0] = evt.cache_instr_stall;
        mdep[0] = 1'b0;
      end
      pecs_pkg::EV_LTU_ST: hit[0] = evt.ltu_stall;
      pecs_pkg::EV_OTH_ST: hit[0] = evt.c0_hwr_stall;
      pecs_pkg::EV_TRIG: hit[0] = evt.itrig;
      pecs_pkg::EV_OCC_A: begin hit[0] = fill_b0; mdep[0] = 1'b0; end
      pecs_pkg::EV_OCC_B: begin hit[0] = fill_b2; mdep[0] = 1'b0; end
      pecs_pkg::EV_OCC_C: begin hit[0] = wtb_b0; mdep[0] = 1'b0; end
      pecs_pkg::EV_OCC_D: begin hit[0] = wtb_b2; mdep[0] = 1'b0; end
      default: hit[0] = 1'b0;
    endcase
  end

  always_comb
  begin
    hit[1] = 1'b0;
    mdep[1] = 1'b1;
    case (ev[1])
      pecs_pkg::EV_CYCLES: begin hit[1] = 1'b1; mdep[1] = 1'b0; end
      pecs_pkg::EV_JOINT_I: hit[1] = evt.joint_i_miss;
      pecs_pkg::EV_JOINT_D: hit[1] = evt.joint_d_miss;
      pecs_pkg::EV_ICACHE: hit[1] = evt.icache_miss_bus;
      pecs_pkg::EV_DCACHE: hit[1] = evt.dcache_wb;
      pecs_pkg::EV_DMISS: hit[1] = evt.dcache_miss;
      pecs_pkg::EV_STCOND: hit[1] = evt.stcond_fail;
      pecs_pkg::EV_PFETCH: hit[1] = evt.pfetch_hit;
      pecs_pkg::EV_GSTALL:
      begin
        hit[1] = evt.alu_stall;
        mdep[1] = 1'b0;
      end
      pecs_pkg::EV_MOD_A: hit[1] = cfg.cop2 & evt.cop2_evt;
      pecs_pkg::EV_MOD_B: hit[1] = cfg.dspr & evt.dspr_evt;
      pecs_pkg::EV_MISS_ST: hit[1] = evt.dmiss_load_stall;
      pecs_pkg::EV_COP2_ST: hit[1] = evt.cext_stall;
      pecs_pkg::EV_SPR_ST: hit[1] = evt.dspr_stall;
      pecs_pkg::EV_TRIG: hit[1] = evt.dtrig;
      pecs_pkg::EV_OCC_A: begin hit[1] = fill_b1; mdep[1] = 1'b0; end
      pecs_pkg::EV_OCC_B:
      begin
        hit[1] = evt.fill_full_stall;
        mdep[1] = 1'b0;
      end
      pecs_pkg::EV_OCC_C: begin hit[1] = wtb_b1; mdep[1] = 1'b0; end
      pecs_pkg::EV_OCC_D:
      begin
        hit[1] = evt.wtb_full_stall;
        mdep[1] = 1'b0;
      end
      default: hit[1] = 1'b0;
    endcase
  end

  // ==========================================================
  // Counters and control registers
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_ctr
      wire kern = ~mode.user_mode & ~mode.exception_level_bit;
      wire mode_ok = (mode.user_mode & ctl_q[g][pecs_pkg::CTL_USER]) |
                     (kern & ctl_q[g][pecs_pkg::CTL_KERN]) |
                     (~mode.user_mode & mode.exception_level_bit &
                      ctl_q[g][pecs_pkg::CTL_EXC_LVL]);
      assign inc[g] = hit[g] & ~blocked & (~mdep[g] | mode_ok);
      wire wr_ctl = ctl_we & (sel == g[0]);
      wire wr_cnt = cnt_we & (sel == g[0]);

      // Reset clears control, selecting event 0, so cycles count until software reprograms it
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
          ctl_q[g] <= pecs_pkg::CTL_RESET;
        else if (wr_ctl)
          ctl_q[g] <= wdata & pecs_pkg::CTL_MASK;
      end

      // No reset on the count: its value after reset is left undefined
      always_ff @(posedge mclk)
      begin
        if (wr_cnt)
          cnt_q[g] <= wdata;
        else if (inc[g])
          cnt_q[g] <= cnt_q[g] + pecs_pkg::CNT_ONE;
      end
    end
  endgenerate

  // ==========================================================
  // Read data and interrupt, registered
  wire irq_d = (ctl_q[0][pecs_pkg::CTL_IRQ] & cnt_q[0][pecs_pkg::CNT_MSB]) |
               (ctl_q[1][pecs_pkg::CTL_IRQ] & cnt_q[1][pecs_pkg::CNT_MSB]);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ctl_rd_q <= pecs_pkg::CTL_RESET;
      cnt_rd_q <= pecs_pkg::CTL_RESET;
      irq_q <= 1'b0;
    end
    else
    begin
      ctl_rd_q <= ctl_q[sel];
      cnt_rd_q <= cnt_q[sel];
      irq_q <= irq_d;
    end
  end
  assign ctl_rdata = ctl_rd_q;
  assign cnt_rdata = cnt_rd_q;
  assign irq = irq_q;

  // ==========================================================
  // Count known once software wrote it
  // Checks on count steps and holds wait for this, as the count has no reset
  logic [1:0] seen_q;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      seen_q <= 2'b00;
    else
      seen_q <= seen_q | {cnt_we & sel, cnt_we & ~sel};
  end

  // ==========================================================
  // Checks
  property p_irq_gate;
    @(posedge mclk) disable iff (rst)
      ~ctl_q[0][pecs_pkg::CTL_IRQ] & ~ctl_q[1][pecs_pkg::CTL_IRQ] |=> ~irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq raised with enables clear");

  property p_blocked;
    @(posedge mclk) disable iff (rst)
      blocked |-> inc == 2'b00;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("count while debug or error level");

  property p_inc;
    @(posedge mclk) disable iff (rst)
      seen_q[0] & inc[0] & ~(ctl_we | cnt_we) |=>
      cnt_q[0] == $past(cnt_q[0]) + 32'h1;
  endproperty
  a_inc: assert property (p_inc)
    else $error("counter 0 did not step by one");

  property p_hold;
    @(posedge mclk) disable iff (rst)
      seen_q[1] & ~inc[1] & ~cnt_we |=> $stable(cnt_q[1]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter 1 moved without event");

  property p_write;
    @(posedge mclk) disable iff (rst)
      cnt_we & ~sel |=> cnt_q[0] == $past(wdata);
  endproperty
  a_write: assert property (p_write)
    else $error("counter write lost");

  property p_wr_ctl;
    @(posedge mclk) disable iff (rst)
      ctl_we & ~sel |=> ctl_q[0] == ($past(wdata) & pecs_pkg::CTL_MASK);
  endproperty
  a_wr_ctl: assert property (p_wr_ctl)
    else $error("control write not masked or lost");

  sequence s_redirect;
    evt.redirect ##1 1'b1;
  endsequence
  property p_redir;
    @(posedge mclk) disable iff (rst)
      s_redirect |-> in_redir [*4];
  endproperty
  a_redir: assert property (p_redir)
    else $error("redirect window shorter than four cycles");

  property p_stall_once;
    @(posedge mclk) disable iff (rst)
      seen_q[0] & (ev[0] == pecs_pkg::EV_STALL) & ~blocked & ~ctl_we &
      ~cnt_we & evt.fetch_no_valid & evt.alu_stall |=>
      cnt_q[0] == $past(cnt_q[0]) + 32'h1;
  endproperty
  a_stall_once: assert property (p_stall_once)
    else $error("overlapping stall not counted once");

  property p_module;
    @(posedge mclk) disable iff (rst)
      (ev[1] == pecs_pkg::EV_MOD_A) & ~cfg.cop2 |-> ~hit[1];
  endproperty
  a_module: assert property (p_module)
    else $error("absent module event counted");
endmodule

// ==== rtl/pecs_pkg.sv ====
package pecs_pkg;
  // Event numbers
  localparam logic [5:0] EV_CYCLES = 6'h00;
  localparam logic [5:0] EV_JOINT_I = 6'h07;
  localparam logic [5:0] EV_JOINT_D = 6'h08;
  localparam logic [5:0] EV_ICACHE = 6'h09;
  localparam logic [5:0] EV_DCACHE = 6'h0a;
  localparam logic [5:0] EV_DMISS = 6'h0b;
  localparam logic [5:0] EV_STALL = 6'h12;
  localparam logic [5:0] EV_STCOND = 6'h13;
  localparam logic [5:0] EV_PFETCH = 6'h14;
  localparam logic [5:0] EV_EXC = 6'h17;
  localparam logic [5:0] EV_FIXUP = 6'h18;
  localparam logic [5:0] EV_GSTALL = 6'h19;
  localparam logic [5:0] EV_MOD_A = 6'h1c;
  localparam logic [5:0] EV_MOD_B = 6'h1d;
  localparam logic [5:0] EV_MOD_C = 6'h1e;
  localparam logic [5:0] EV_MISS_ST = 6'h25;
  localparam logic [5:0] EV_DMISS_CY = 6'h27;
  localparam logic [5:0] EV_UNC_ST = 6'h28;
  localparam logic [5:0] EV_MULDIV_ST = 6'h29;
  localparam logic [5:0] EV_COP2_ST = 6'h2a;
  localparam logic [5:0] EV_SPR_ST = 6'h2b;
  localparam logic [5:0] EV_CACHE_ST = 6'h2c;
  localparam logic [5:0] EV_LTU_ST = 6'h2d;
  localparam logic [5:0] EV_OTH_ST = 6'h2e;
  localparam logic [5:0] EV_TRIG = 6'h31;
  localparam logic [5:0] EV_OCC_A = 6'h34;
  localparam logic [5:0] EV_OCC_B = 6'h35;
  localparam logic [5:0] EV_OCC_C = 6'h36;
  localparam logic [5:0] EV_OCC_D = 6'h37;
  // Control register field positions
  localparam int CTL_EVT_LO = 5;
  localparam int CTL_EVT_HI = 10;
  localparam int CTL_IRQ = 4;
  localparam int CTL_USER = 3;
  localparam int CTL_KERN = 1;
  localparam int CTL_EXC_LVL = 0;
  localparam int CNT_MSB = 31;
  localparam logic [31:0] CTL_MASK = 32'h0000_07fb;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] CNT_ONE = 32'h0000_0001;
  // Post-redirect exclusion window
  localparam int REDIR_CYCLES = 4;
  localparam logic [2:0] REDIR_LOAD = 3'h4;
  // Buffer occupancy thresholds
  localparam logic [3:0] OCC4_LO = 4'h1;
  localparam logic [3:0] OCC4_HI = 4'h3;
  localparam logic [3:0] OCC8_LO = 4'h2;
  localparam logic [3:0] OCC8_HI = 4'h5;
  // Event pulses from the core
  typedef struct packed {
    logic instr_tb_miss;
    logic joint_i_miss;
    logic joint_d_acc;
    logic joint_d_miss;
    logic icache_acc;
    logic icache_miss_bus;
    logic dcache_acc;
    logic dcache_wb;
    logic dcache_miss;
    logic stcond_fail;
    logic pfetch_hit;
    logic exc_taken;
    logic dc_fixup;
    logic fetch_no_valid;
    logic alu_stall;
    logic icache_miss_stall;
    logic instr_tb_stall;
    logic redirect;
    logic dmiss_load_stall;
    logic dmiss_outstanding;
    logic uncached_stall;
    logic muldiv_stall;
    logic cop2_stall;
    logic cext_stall;
    logic ispr_multi;
    logic dspr_stall;
    logic cache_instr_stall;
    logic ltu_stall;
    logic c0_hwr_stall;
    logic fill_full_stall;
    logic wtb_full_stall;
    logic itrig;
    logic dtrig;
    logic cop2_evt;
    logic ispr_evt;
    logic dspr_evt;
    logic cext_evt;
  } pecs_evt_t;
  typedef struct packed {
    logic cop2;
    logic ispr;
    logic dspr;
    logic cext;
    logic fill_big;
    logic wtb_big;
  } pecs_cfg_t;
  typedef struct packed {
    logic debug_mode;
    logic error_level_bit;
    logic exception_level_bit;
    logic user_mode;
  } pecs_mode_t;
  typedef enum logic [1:0] {
    PECS_RUN = 2'b00,
    PECS_REDIR = 2'b01
  } pecs_state_t;
endpackage

// ==== tb/pecs_core_model.sv ====
`timescale 1ns/1ns
// ============================================================
// Event source model: pipeline and cache pulses
module pecs_core_model
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic go,
  input wire logic slow,
  input wire logic [36:0] head,
  input wire logic [36:0] mask,
  input wire logic [7:0] len,
  output pecs_pkg::pecs_evt_t evt,
  output logic busy
);
  logic [7:0] left_q;
  logic first_q;
  logic gap_q;
  assign busy = (left_q != 8'h00) || (evt != '0);
  // Slow mode idles between pulses, as a stalled pipeline would
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      left_q <= 8'h00;
      first_q <= 1'b0;
      gap_q <= 1'b0;
      evt <= '0;
    end
    else if (go)
    begin
      left_q <= len;
      first_q <= 1'b1;
      gap_q <= 1'b0;
    end
    else if (left_q != 8'h00 && !(slow && gap_q))
    begin
      evt <= first_q ? head : mask;
      left_q <= left_q - 8'h01;
      first_q <= 1'b0;
      gap_q <= 1'b1;
    end
    else
    begin
      evt <= '0;
      gap_q <= 1'b0;
    end
  end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ns
// ============================================================
// Bench signals
module tb;
  typedef struct packed {logic s; logic [5:0] ev; logic [5:0] b;} pecs_case_t;
  localparam pecs_case_t CASES [33] = '{
    '{1'b0, 6'h07, 6'h24},
    '{1'b1, 6'h07, 6'h23}, '{1'b1, 6'h08, 6'h21},
    '{1'b0, 6'h09, 6'h20},
    '{1'b1, 6'h09, 6'h1f},
    '{1'b0, 6'h0a, 6'h1e}, '{1'b1, 6'h0a, 6'h1d},
    '{1'b0, 6'h0b, 6'h1c}, '{1'b1, 6'h0b, 6'h1c},
    '{1'b1, 6'h13, 6'h1b},
    '{1'b1, 6'h14, 6'h1a},
    '{1'b0, 6'h17, 6'h19},
    '{1'b0, 6'h31, 6'h05}, '{1'b1, 6'h31, 6'h04},
    '{1'b0, 6'h18, 6'h18},
    '{1'b0, 6'h19, 6'h17}, '{1'b1, 6'h19, 6'h16},
    '{1'b1, 6'h25, 6'h12}, '{1'b0, 6'h27, 6'h11},
    '{1'b0, 6'h28, 6'h10}, '{1'b0, 6'h29, 6'h0f},
    '{1'b0, 6'h2a, 6'h0e}, '{1'b1, 6'h2a, 6'h0d},
    '{1'b1, 6'h2b, 6'h0b},
    '{1'b0, 6'h2c, 6'h0a}, '{1'b0, 6'h2d, 6'h09},
    '{1'b0, 6'h2e, 6'h08},
    '{1'b1, 6'h35, 6'h07}, '{1'b1, 6'h37, 6'h06},
    '{1'b1, 6'h1c, 6'h03}, '{1'b0, 6'h1d, 6'h02},
    '{1'b1, 6'h1d, 6'h01}, '{1'b0, 6'h1e, 6'h00}};
  // Mode, control mode bits, counts-or-not
  localparam logic [11:0] MODES [6] = '{12'h8b0, 12'h4b0, 12'h120,
    12'h181, 12'h220, 12'h211};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  pecs_pkg::pecs_evt_t evt;
  pecs_pkg::pecs_cfg_t cfg = pecs_pkg::pecs_cfg_t'(6'h3c);
  pecs_pkg::pecs_mode_t mode = '0;
  logic [3:0] fill_occ = 4'h0;
  logic [3:0] wtb_occ = 4'h0;
  logic sel = 1'b0;
  logic ctl_we = 1'b0;
  logic cnt_we = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] ctl_rdata;
  logic [31:0] cnt_rdata;
  logic irq;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [36:0] head = '0;
  logic [36:0] mask = '0;
  logic [7:0] len = 8'h00;
  logic busy;
  logic [7:0] r = 8'h17;
  logic [33:0] exp_q [$];
  logic [33:0] e;
  logic [31:0] got;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  event look;
  always #20 mclk = ~mclk;
  pecs_counters pecs_counters_inst (.mclk(mclk), .rst(rst), .evt(evt),
    .cfg(cfg), .mode(mode), .fill_occ(fill_occ), .wtb_occ(wtb_occ),
    .sel(sel), .ctl_we(ctl_we), .cnt_we(cnt_we), .wdata(wdata),
    .ctl_rdata(ctl_rdata), .cnt_rdata(cnt_rdata), .irq(irq));
  pecs_core_model pecs_core_model_inst (.mclk(mclk), .rst(rst), .go(go),
    .slow(slow), .head(head), .mask(mask), .len(len), .evt(evt),
    .busy(busy));
  // ============================================================
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [1:0] bin(input logic big, input logic [3:0] o);
    if (big)
      return o < 4'h2 ? 2'h0 : (o < 4'h5 ? 2'h1 : 2'h2);
    return o == 4'h0 ? 2'h0 : (o < 4'h3 ? 2'h1 : 2'h2);
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [1:0] k, input logic [31:0] v);
    exp_q.push_back({k, v});
    -> look;
    @(posedge mclk);
  endtask
  // Read data is registered, so let two edges pass before looking
  task automatic rd(input logic [1:0] k, input logic [31:0] v);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(k, v);
  endtask
  // Strobe drops for a full cycle so back-to-back calls never collide
  task automatic wr(input logic c, input logic s, input logic [31:0] d);
    sel <= s;
    wdata <= d;
    ctl_we <= ~c;
    cnt_we <= c;
    @(posedge mclk);
    ctl_we <= 1'b0;
    cnt_we <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic run(input logic s, input logic [31:0] c,
    input logic [36:0] h, input logic [36:0] m, input logic [7:0] n,
    input logic sl, input logic [31:0] i);
    int g = 0;
    wr(1'b0, s, c);
    wr(1'b1, s, i);
    head <= h;
    mask <= m;
    len <= n;
    slow <= sl;
    wtb_occ <= r[3:0];
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    do
    begin
      @(negedge mclk);
      g++;
    end
    while (busy && g < 40);
    @(posedge mclk);
  endtask
  task automatic occ_run(input int k, input logic big, input logic [3:0] o);
    logic s;
    s = (k == 1);
    cfg.fill_big <= big;
    fill_occ <= o;
    wr(1'b1, s, 32'h0);
    wr(1'b0, s, {21'h0, k == 2 ? 6'h35 : 6'h34, 5'h00});
    repeat (4) @(posedge mclk);
    wr(1'b0, s, 32'h7e0);
    rd(2'd0, bin(big, o) == k[1:0] ? 32'h6 : 32'h0);
  endtask
  // ============================================================
  // Result watcher
  always @(look)
  begin
    e = exp_q.pop_front();
    got = e[33:32] == 2'd1 ? {31'h0, irq} :
      (e[33:32] == 2'd2 ? ctl_rdata : cnt_rdata);
    checks_done++;
    if (got !== e[31:0])
    begin
      miscompares++;
      $display("BAD t=%0t exp=%h got=%h", $time, e[31:0], got);
    end
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      stop_test();
    end
  end
  // ============================================================
  // Main sequence
  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(2'd2, 32'h0);
    foreach (CASES[j])
    begin
      r = lfsr(r);
      run(CASES[j].s, {21'h0, CASES[j].ev, 5'h02}, 37'h1 << CASES[j].b,
        37'h1 << CASES[j].b, {5'h0, r[2:0]} + 8'h1, r[3], 32'h0);
      rd(2'd0, {29'h0, r[2:0]} + 32'h1);
    end
    $display("done: event table");
    foreach (MODES[j])
    begin
      mode <= pecs_pkg::pecs_mode_t'(MODES[j][11:8]);
      run(1'b0, {21'h0, 6'h09, 1'b0, MODES[j][7:4]}, 37'h100000000,
        37'h100000000, 8'h4, 1'b0, 32'h0);
      rd(2'd0, MODES[j][0] ? 32'h4 : 32'h0);
    end
    mode <= '0;
    $display("done: modes");
    cfg.cop2 <= 1'b0;
    run(1'b1, 32'h382, 37'h8, 37'h8, 8'h3, 1'b0, 32'h0);
    rd(2'd0, 32'h0);
    cfg.cop2 <= 1'b1;
    run(1'b0, 32'h240, 37'hc00000, 37'hc00000, 8'h5, 1'b1, 32'h0);
    rd(2'd0, 32'h5);
    run(1'b0, 32'h4a2, 37'h80000, 37'h200000, 8'h7, 1'b0, 32'h0);
    rd(2'd0, 32'h2);
    run(1'b0, 32'h4a2, 37'h300000, 37'h300000, 8'h4, 1'b1, 32'h0);
    rd(2'd0, 32'h0);
    run(1'b0, 32'h562, 37'h80000, 37'h1000, 8'h7, 1'b0, 32'h0);
    rd(2'd0, 32'h2);
    $display("done: stalls");
    run(1'b0, 32'h132, 37'h100000000, 37'h100000000, 8'h1, 1'b0,
      32'h7fffffff);
    rd(2'd0, 32'h80000000);
    @(negedge mclk);
    chk(2'd1, 32'h1);
    run(1'b0, 32'h132, 37'h100000000, 37'h100000000, 8'h2, 1'b1,
      32'hffffffff);
    rd(2'd0, 32'h1);
    run(1'b0, 32'h122, 37'h100000000, 37'h100000000, 8'h1, 1'b0,
      32'h7fffffff);
    @(negedge mclk);
    chk(2'd1, 32'h0);
    r = lfsr(r);
    wr(1'b1, 1'b1, {4{r}});
    rd(2'd0, {4{r}});
    wr(1'b0, 1'b0, 32'hffffffff);
    rd(2'd2, 32'h7fb);
    $display("done: registers");
    wr(1'b0, 1'b1, 32'h7e0);
    for (int b = 0; b < 2; b++)
      for (int o = 0; o < 6; o++)
        for (int k = 0; k < 3; k++)
          occ_run(k, b[0], o[3:0]);
    $display("done: occupancy");
    stop_test();
  end
endmodule
